// ==== logic/lp_cfg_pkg.sv ====
// shared constants of the low-power polling configuration block
package lp_cfg_pkg;
	// =========================================================
	// frame layout
	localparam int FRAME_W = 32;
	localparam int ADDR_MSB = 31;
	localparam int ADDR_LSB = 25;
	localparam int RW_BIT = 24;
	localparam int DATA_W = 24;
	localparam int FAULT_BIT = 23;
	localparam int INT_BIT = 22;
	localparam int REG_W = 22;
	localparam int BITCNT_W = 6;
	localparam logic [5:0] FRAME_BITS = 6'h20;
	// =========================================================
	// register addresses
	localparam logic [6:0] ADDR_SLOW_GND = 7'h19;
	localparam logic [6:0] ADDR_DEB_PROG = 7'h1a;
	localparam logic [6:0] ADDR_DEB_GND = 7'h1b;
	localparam logic [6:0] ADDR_SLEEP = 7'h1c;
	localparam logic [6:0] ADDR_SW_STATUS = 7'h1f;
	localparam logic [6:0] ADDR_FAULT_STATUS = 7'h3e;
	localparam logic [23:0] SLEEP_DATA = 24'h000000;
	// =========================================================
	// channel counts and reset values
	localparam int GND_CH = 14;
	localparam int PROG_CH = 8;
	localparam logic [13:0] RST_SLOW_GND = 14'h0000;
	localparam logic [7:0] RST_DEB_PROG = 8'h00;
	localparam logic [13:0] RST_DEB_GND = 14'h0000;
	// slow polling skips three of every four base ticks
	localparam logic [1:0] SLOW_PHASE = 2'h0;
	// =========================================================
	// timing
	localparam int CLK_NS = 10;
	localparam int DEBOUNCE_NS = 1200000;
	localparam int DEBOUNCE_CYC = DEBOUNCE_NS / CLK_NS;
	localparam int POLL_NS = 640;
	localparam int POLL_CYC = (POLL_NS + CLK_NS - 1) / CLK_NS;
	localparam int WIN_W = 17;
	localparam logic [2:0] SPI_SYNC_RST = 3'h2;
endpackage

// ==== logic/tick_divider.sv ====
// enable-pulse divider for the low-power polling period
`timescale 1ns/1ps
module tick_divider (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// control
	input wire logic en_i,
	input wire logic [15:0] period_i,
	// one-cycle tick
	output logic tick_o
);
	logic [15:0] cnt;

	// a period of zero acts as one so the tick never stops
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt <= 16'h0000;
			tick_o <= 1'b0;
		end else if (!en_i) begin
			cnt <= 16'h0000;
			tick_o <= 1'b0;
		end else if (cnt + 16'h0001 >= period_i) begin
			cnt <= 16'h0000;
			tick_o <= 1'b1;
		end else begin
			cnt <= cnt + 16'h0001;
			tick_o <= 1'b0;
		end
	end
endmodule

// ==== logic/spi_frame_slave.sv ====
// oversampled spi slave that moves one 32-bit frame per chip select
`timescale 1ns/1ps
module spi_frame_slave (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// spi pins
	input wire logic sck_i,
	input wire logic cs_n_i,
	input wire logic mosi_i,
	output logic miso_o,
	output logic miso_oe_o,
	// frame side
	input wire logic [31:0] reply_i,
	output logic frame_start_o,
	output logic frame_valid_o,
	output logic [31:0] frame_o
);
	// bit 0 sck, bit 1 cs_n, bit 2 mosi
	logic [2:0] s0, s1, s2, filt, filt_d, agree;
	logic [31:0] rx, tx;
	logic [5:0] cnt;
	logic sck_rise, cs_fall, cs_rise;

	// =========================================================
	// three-stage sampling, a change counts when stages agree
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s0 <= lp_cfg_pkg::SPI_SYNC_RST;
			s1 <= lp_cfg_pkg::SPI_SYNC_RST;
			s2 <= lp_cfg_pkg::SPI_SYNC_RST;
			filt <= lp_cfg_pkg::SPI_SYNC_RST;
			filt_d <= lp_cfg_pkg::SPI_SYNC_RST;
		end else begin
			s0 <= {mosi_i, cs_n_i, sck_i};
			s1 <= s0;
			s2 <= s1;
			filt <= (s1 & agree) | (filt & ~agree);
			filt_d <= filt;
		end
	end
	assign agree = ~(s1 ^ s2);
	assign sck_rise = filt[0] & ~filt_d[0] & ~filt[1];
	assign cs_fall = filt_d[1] & ~filt[1];
	assign cs_rise = ~filt_d[1] & filt[1];
	assign frame_start_o = cs_fall;
	assign miso_o = tx[31];
	assign miso_oe_o = ~filt[1];

	// =========================================================
	// shifting: capture and launch on rising sck
	// launching on the falling pin edge would land five clocks late,
	// after the host has already sampled at its next rising edge
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rx <= 32'h00000000;
			tx <= 32'h00000000;
			cnt <= 6'h00;
		end else if (cs_fall) begin
			tx <= reply_i;
			cnt <= 6'h00;
		end else begin
			if (sck_rise) begin
				rx <= {rx[30:0], filt[2]};
				tx <= {tx[30:0], 1'b0};
				if (cnt != 6'h3f) begin
					cnt <= cnt + 6'h01;
				end
			end
		end
	end

	// frames of any other length are dropped whole
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			frame_valid_o <= 1'b0;
			frame_o <= 32'h00000000;
		end else begin
			frame_valid_o <= cs_rise && cnt == lp_cfg_pkg::FRAME_BITS;
			if (cs_rise && cnt == lp_cfg_pkg::FRAME_BITS) begin
				frame_o <= rx;
			end
		end
	end
endmodule

// ==== logic/low_power_polling_config.sv ====
// configuration registers, sleep command and low-power polling sequencer
// =========================================================
// Notes on behaviour
// - one frame: address, read/write, 24 data
// - slow-poll bit polls ground channel four times slower
// - ground slow-poll register at 0x19, resets zero
// - reply holds fault, interrupt, then register data
// - clear debounce bit: judge by voltage difference
// - set debounce bit: source 1.2 ms more, judge level
// - programmable debounce register at 0x1a, eight bits
// - ground debounce register at 0x1b, fourteen bits
// - only the sleep command enters low power
// - sleep command: 0x1c, write, all data zero
// - sleep command starts polling and the interrupt timer
// - configuration kept across low power mode
// - first reply after wake: both flags, inputs
// - base polling period comes from separate register
// - status read clears interrupt; fault read clears fault
`timescale 1ns/1ps
module low_power_polling_config #(
	parameter int DEBOUNCE_CYCLES = lp_cfg_pkg::DEBOUNCE_CYC,
	parameter int POLL_CYCLES = lp_cfg_pkg::POLL_CYC
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// spi pins
	input wire logic sck_i,
	input wire logic cs_n_i,
	input wire logic mosi_i,
	output logic miso_o,
	output logic miso_oe_o,
	// device state from neighbouring logic
	input wire logic fault_summary_i,
	input wire logic int_flag_i,
	input wire logic [21:0] switch_state_i,
	input wire logic wake_i,
	input wire logic [15:0] lp_period_i,
	// flag clears towards neighbouring logic
	output logic int_clear_o,
	output logic fault_clear_o,
	// low-power control
	output logic low_power_mode_o,
	output logic int_timer_run_o,
	output logic [13:0] source_gnd_o,
	output logic [7:0] source_prog_o,
	output logic [13:0] judge_diff_gnd_o,
	output logic [7:0] judge_diff_prog_o,
	output logic [13:0] judge_level_gnd_o,
	output logic [7:0] judge_level_prog_o
);
	typedef enum logic [1:0] {P_IDLE, P_POLL, P_EXTEND} poll_state_t;

	logic frame_start, frame_valid;
	logic [31:0] frame, last_frame, reply;
	logic [6:0] f_addr, l_addr;
	logic f_rw, l_rw, enter_cmd, wake_pending, wake_now;
	logic [23:0] f_data;
	logic [13:0] slow_gnd, deb_gnd, mask_gnd;
	logic [7:0] deb_prog;
	logic [21:0] reg_data;
	logic base_tick;
	logic [1:0] quarter;
	logic [16:0] win_cnt;
	poll_state_t pstate;
	logic [16:0] ext_len;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	// =========================================================
	// serial link
	spi_frame_slave u_spi (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.sck_i(sck_i),
		.cs_n_i(cs_n_i),
		.mosi_i(mosi_i),
		.miso_o(miso_o),
		.miso_oe_o(miso_oe_o),
		.reply_i(reply),
		.frame_start_o(frame_start),
		.frame_valid_o(frame_valid),
		.frame_o(frame)
	);

	// frame fields
	assign f_addr = frame[lp_cfg_pkg::ADDR_MSB:lp_cfg_pkg::ADDR_LSB];
	assign f_rw = frame[lp_cfg_pkg::RW_BIT];
	assign f_data = frame[lp_cfg_pkg::DATA_W-1:0];
	assign l_addr = last_frame[lp_cfg_pkg::ADDR_MSB:lp_cfg_pkg::ADDR_LSB];
	assign l_rw = last_frame[lp_cfg_pkg::RW_BIT];
	assign enter_cmd = frame_valid && f_rw && f_addr == lp_cfg_pkg::ADDR_SLEEP
		&& f_data == lp_cfg_pkg::SLEEP_DATA;

	// =========================================================
	// configuration registers, untouched by mode changes
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			slow_gnd <= lp_cfg_pkg::RST_SLOW_GND;
			deb_prog <= lp_cfg_pkg::RST_DEB_PROG;
			deb_gnd <= lp_cfg_pkg::RST_DEB_GND;
		end else if (frame_valid && f_rw) begin
			// only the channel bits are stored, the rest is dropped
			unique case (f_addr)
				lp_cfg_pkg::ADDR_SLOW_GND: slow_gnd <= f_data[13:0];
				lp_cfg_pkg::ADDR_DEB_PROG: deb_prog <= f_data[7:0];
				lp_cfg_pkg::ADDR_DEB_GND: deb_gnd <= f_data[13:0];
				default: begin
				end
			endcase
		end
	end

	// the previous frame decides what the next reply carries
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			last_frame <= 32'h00000000;
		end else if (frame_valid) begin
			last_frame <= frame;
		end
	end

	// =========================================================
	// reply word, built when chip select falls
	always_comb begin
		reg_data = 22'h000000;
		if (wake_pending) begin
			reg_data = switch_state_i;
		end else if (!l_rw && l_addr == lp_cfg_pkg::ADDR_SW_STATUS) begin
			reg_data = switch_state_i;
		end else begin
			unique case (l_addr)
				lp_cfg_pkg::ADDR_SLOW_GND: reg_data = {8'h00, slow_gnd};
				lp_cfg_pkg::ADDR_DEB_PROG: reg_data = {14'h0000, deb_prog};
				lp_cfg_pkg::ADDR_DEB_GND: reg_data = {8'h00, deb_gnd};
				default: reg_data = 22'h000000; // the sleep command reads as zero
			endcase
		end
	end
	// the upper byte echoes the previous command
	assign reply = {last_frame[31:24], fault_summary_i | wake_pending,
		int_flag_i | wake_pending, reg_data};

	// =========================================================
	// flag clears by reading the status registers
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			int_clear_o <= 1'b0;
			fault_clear_o <= 1'b0;
		end else begin
			int_clear_o <= frame_valid && !f_rw
				&& f_addr == lp_cfg_pkg::ADDR_SW_STATUS;
			fault_clear_o <= frame_valid && !f_rw
				&& f_addr == lp_cfg_pkg::ADDR_FAULT_STATUS;
		end
	end

	// =========================================================
	// mode control: a chip select or a wake event ends sleep
	assign wake_now = low_power_mode_o && (wake_i || frame_start);
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			low_power_mode_o <= 1'b0;
		end else if (wake_now) begin
			low_power_mode_o <= 1'b0;
		end else if (enter_cmd) begin
			low_power_mode_o <= 1'b1;
		end
	end
	assign int_timer_run_o = low_power_mode_o;

	// set wins: a wake on a frame start leaves the flags pending
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wake_pending <= 1'b0;
		end else if (low_power_mode_o && wake_i) begin
			wake_pending <= 1'b1;
		end else if (frame_start) begin
			wake_pending <= low_power_mode_o;
		end
	end

	// =========================================================
	// polling timebase from the separate low-power rate register
	tick_divider u_rate (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.en_i(low_power_mode_o),
		.period_i(lp_period_i),
		.tick_o(base_tick)
	);

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			quarter <= 2'h0;
		end else if (!low_power_mode_o) begin
			quarter <= 2'h0;
		end else if (base_tick) begin
			quarter <= quarter + 2'h1;
		end
	end
	// slow channels join only one base tick in four
	assign mask_gnd = ~slow_gnd
		| {14{quarter == lp_cfg_pkg::SLOW_PHASE}};

	// =========================================================
	// polling sequencer; a tick during a running poll is skipped
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pstate <= P_IDLE;
			win_cnt <= 17'h00000;
			source_gnd_o <= 14'h0000;
			source_prog_o <= 8'h00;
		end else if (!low_power_mode_o) begin
			pstate <= P_IDLE;
			win_cnt <= 17'h00000;
			source_gnd_o <= 14'h0000;
			source_prog_o <= 8'h00;
		end else begin
			unique case (pstate)
				P_IDLE: begin
					if (base_tick) begin
						pstate <= P_POLL;
						win_cnt <= 17'(POLL_CYCLES - 1);
						source_gnd_o <= mask_gnd;
						source_prog_o <= 8'hff;
					end
				end
				P_POLL: begin
					if (win_cnt != 17'h00000) begin
						win_cnt <= win_cnt - 17'h00001;
					end else if ((source_gnd_o & deb_gnd) != 14'h0000
						|| (source_prog_o & deb_prog) != 8'h00) begin
						pstate <= P_EXTEND;
						win_cnt <= 17'(DEBOUNCE_CYCLES - 1);
						source_gnd_o <= source_gnd_o & deb_gnd;
						source_prog_o <= source_prog_o & deb_prog;
					end else begin
						pstate <= P_IDLE;
						source_gnd_o <= 14'h0000;
						source_prog_o <= 8'h00;
					end
				end
				P_EXTEND: begin
					if (win_cnt != 17'h00000) begin
						win_cnt <= win_cnt - 17'h00001;
					end else begin
						pstate <= P_IDLE;
						source_gnd_o <= 14'h0000;
						source_prog_o <= 8'h00;
					end
				end
			endcase
		end
	end

	// judgement strobes at the end of each window
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			judge_diff_gnd_o <= 14'h0000;
			judge_diff_prog_o <= 8'h00;
			judge_level_gnd_o <= 14'h0000;
			judge_level_prog_o <= 8'h00;
		end else begin
			judge_diff_gnd_o <= 14'h0000;
			judge_diff_prog_o <= 8'h00;
			judge_level_gnd_o <= 14'h0000;
			judge_level_prog_o <= 8'h00;
			if (low_power_mode_o && win_cnt == 17'h00000) begin
				if (pstate == P_POLL) begin
					judge_diff_gnd_o <= source_gnd_o & ~deb_gnd;
					judge_diff_prog_o <= source_prog_o & ~deb_prog;
				end else if (pstate == P_EXTEND) begin
					judge_level_gnd_o <= source_gnd_o;
					judge_level_prog_o <= source_prog_o;
				end
			end
		end
	end

	// =========================================================
	// checks
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ext_len <= 17'h00000;
		end else if (pstate == P_EXTEND) begin
			ext_len <= ext_len + 17'h00001;
		end else begin
			ext_len <= 17'h00000;
		end
	end

	sleep_entry_a: assert property (enter_cmd && !wake_now
		|=> low_power_mode_o)
		else $error("sleep command did not enter low power mode");
	sleep_cause_a: assert property ($rose(low_power_mode_o)
		|-> $past(enter_cmd))
		else $error("low power mode entered without the command");
	config_kept_a: assert property ($fell(low_power_mode_o)
		|-> $stable(slow_gnd) && $stable(deb_gnd)
		&& $stable(deb_prog))
		else $error("configuration changed on wake");
	wake_reply_a: assert property (frame_start && wake_pending
		|-> reply[23:22] == 2'h3 && reply[21:0] == switch_state_i)
		else $error("first reply after wake lacks flags or inputs");
	reply_layout_a: assert property (frame_start && !wake_pending
		&& l_addr == lp_cfg_pkg::ADDR_DEB_PROG
		|-> reply[21:0] == {14'h0000, deb_prog}
		&& reply[22] == int_flag_i
		&& reply[23] == fault_summary_i)
		else $error("reply word layout wrong");
	int_clear_a: assert property (frame_valid && !f_rw
		&& f_addr == lp_cfg_pkg::ADDR_SW_STATUS
		|=> int_clear_o ##1 !int_clear_o)
		else $error("status read did not clear interrupt once");
	slow_poll_a: assert property (pstate == P_IDLE && base_tick
		&& low_power_mode_o && quarter != lp_cfg_pkg::SLOW_PHASE
		|=> (source_gnd_o & slow_gnd) == 14'h0000)
		else $error("slow channel polled on a skipped tick");
	debounce_len_a: assert property ($fell(pstate == P_EXTEND)
		&& $past(low_power_mode_o)
		|-> ext_len == 17'(DEBOUNCE_CYCLES))
		else $error("debounce extension length wrong");
	unused_zero_a: assert property (frame_valid && f_rw
		&& f_addr == lp_cfg_pkg::ADDR_SLOW_GND
		|=> slow_gnd == $past(f_data[13:0]))
		else $error("slow poll write not stored as channel bits");
endmodule

// ==== sim/spi_host_model.sv ====
// host-side spi master model that moves one 32-bit frame per call
`timescale 1ns/1ps
module spi_host_model (
	// clock
	input wire logic clk_i,
	// spi pins
	input wire logic miso_i,
	output logic sck_o,
	output logic cs_n_o,
	output logic mosi_o
);
	initial begin
		sck_o = 1'b0;
		cs_n_o = 1'b1;
		mosi_o = 1'b0;
	end

	task automatic wait_clk(input int n);
		repeat (n) @(posedge clk_i);
	endtask

	// =========================================================
	// frame transfer
	// address, read/write bit, then data, msb first
	task automatic xfer(input logic [31:0] tx, output logic [31:0] rx);
		@(posedge clk_i);
		cs_n_o <= 1'b0;
		mosi_o <= tx[31];
		// the reply word is loaded some clocks after chip select falls
		wait_clk(4);
		for (int i = 31; i >= 0; i--) begin
			wait_clk(4);
			sck_o <= 1'b1;
			rx[i] = miso_i;
			wait_clk(4);
			sck_o <= 1'b0;
			if (i > 0) begin
				mosi_o <= tx[i-1];
			end else begin
				// released line: show the inverse so a stale bit never passes
				mosi_o <= ~tx[0];
			end
		end
		wait_clk(4);
		// link clock stays still while deselected
		cs_n_o <= 1'b1;
		wait_clk(6);
	endtask
endmodule

// ==== sim/test_low_power_polling_config.sv ====
// self-checking bench of the low-power polling configuration block
`timescale 1ns/1ps
module test_low_power_polling_config;
	localparam int DEB = 20;
	localparam int POLL = 4;
	localparam int PER = 50;
	localparam int LIMIT = 20000;
	// chip select low time of one host frame, in clocks
	localparam int CS_LOW = 8 + 32 * 8;
	// =========================================================
	// clock, reset and design signals
	logic clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic sck;
	logic cs_n;
	logic mosi;
	logic miso;
	logic miso_oe;
	logic fault = 1'b1;
	logic intf = 1'b0;
	logic wake = 1'b0;
	logic [21:0] sw = 22'h2a5c3;
	logic [15:0] period = 16'h0032;
	logic int_clr;
	logic flt_clr;
	logic lp;
	logic timer_run;
	logic [13:0] src_g;
	logic [13:0] diff_g;
	logic [13:0] lvl_g;
	logic [7:0] src_p;
	logic [7:0] diff_p;
	logic [7:0] lvl_p;
	int n_fail = 0;
	int comparisons = 0;
	int cyc = 0;
	int n_ic = 0;
	int n_fc = 0;
	int n_slow = 0;
	int n_norm = 0;
	int n_bad = 0;
	int n_lvl = 0;
	int n_lvlp = 0;
	int t_norm = 0;
	int dt_norm = 0;
	int dt_lvl = 0;
	int run_g = 0;
	int len_g = 0;
	int run_p = 0;
	int len_p = 0;
	int run_oe = 0;
	int len_oe = 0;
	// shadow of what the registers should hold
	logic [13:0] sh_slow = 14'h0000;
	logic [13:0] sh_dg = 14'h0000;
	logic [7:0] sh_dp = 8'h00;
	logic [7:0] prev_top = 8'h00;
	logic [6:0] prev_a = 7'h00;
	logic pend = 1'b0;

	always #5 clk_i = ~clk_i;

	low_power_polling_config #(.DEBOUNCE_CYCLES(DEB), .POLL_CYCLES(POLL))
	low_power_polling_config_i (
		.clk_i(clk_i), .rst_n_i(rst_n_i), .sck_i(sck), .cs_n_i(cs_n),
		.mosi_i(mosi), .miso_o(miso), .miso_oe_o(miso_oe),
		.fault_summary_i(fault), .int_flag_i(intf), .switch_state_i(sw),
		.wake_i(wake), .lp_period_i(period), .int_clear_o(int_clr),
		.fault_clear_o(flt_clr), .low_power_mode_o(lp),
		.int_timer_run_o(timer_run), .source_gnd_o(src_g),
		.source_prog_o(src_p), .judge_diff_gnd_o(diff_g),
		.judge_diff_prog_o(diff_p), .judge_level_gnd_o(lvl_g),
		.judge_level_prog_o(lvl_p));

	spi_host_model spi_host_model_i (.clk_i(clk_i), .miso_i(miso),
		.sck_o(sck), .cs_n_o(cs_n), .mosi_o(mosi));

	// =========================================================
	// monitors
	always @(posedge clk_i) begin
		if (int_clr === 1'b1)
			n_ic <= n_ic + 1;
		if (flt_clr === 1'b1)
			n_fc <= n_fc + 1;
		if (diff_g[0] === 1'b1)
			n_slow <= n_slow + 1;
		if (diff_g[1] === 1'b1 || diff_p[0] === 1'b1)
			n_bad <= n_bad + 1;
		if (lvl_p[0] === 1'b1)
			n_lvlp <= n_lvlp + 1;
		if (diff_g[2] === 1'b1) begin
			t_norm <= cyc;
			dt_norm <= cyc - t_norm;
			n_norm <= n_norm + 1;
		end
		if (lvl_g[1] === 1'b1) begin
			dt_lvl <= cyc - t_norm;
			n_lvl <= n_lvl + 1;
		end
		// lengths of the last source and drive windows
		if (src_g[2] === 1'b1)
			run_g <= run_g + 1;
		else if (run_g != 0) begin
			len_g <= run_g;
			run_g <= 0;
		end
		if (src_p[0] === 1'b1)
			run_p <= run_p + 1;
		else if (run_p != 0) begin
			len_p <= run_p;
			run_p <= 0;
		end
		if (miso_oe === 1'b1)
			run_oe <= run_oe + 1;
		else if (run_oe != 0) begin
			len_oe <= run_oe;
			run_oe <= 0;
		end
	end

	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (cyc == LIMIT) begin
			n_fail = n_fail + 1;
			give_verdict();
		end
	end

	// =========================================================
	// helpers
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_fail++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen,
				exp);
		end
	endtask

	function automatic logic [21:0] shadow(input logic [6:0] a);
		case (a)
			lp_cfg_pkg::ADDR_SLOW_GND: shadow = {8'h00, sh_slow};
			lp_cfg_pkg::ADDR_DEB_PROG: shadow = {14'h0000, sh_dp};
			lp_cfg_pkg::ADDR_DEB_GND: shadow = {8'h00, sh_dg};
			lp_cfg_pkg::ADDR_SW_STATUS: shadow = sw;
			default: shadow = 22'h000000;
		endcase
	endfunction

	// one frame; its reply answers the frame before
	task automatic io(input logic [6:0] a, input logic w,
		input logic [23:0] d);
		logic [31:0] rx;
		logic [31:0] exp;
		spi_host_model_i.xfer({a, w, d}, rx);
		// inputs stand still during a frame, so read them afterwards
		exp = {prev_top, fault, intf, shadow(prev_a)};
		if (pend)
			exp[23:0] = {2'b11, sw};
		check(rx, exp);
		check(len_oe, CS_LOW);
		pend = 1'b0;
		prev_top = {a, w};
		prev_a = a;
		if (w && a == lp_cfg_pkg::ADDR_SLOW_GND)
			sh_slow = d[13:0];
		if (w && a == lp_cfg_pkg::ADDR_DEB_PROG)
			sh_dp = d[7:0];
		if (w && a == lp_cfg_pkg::ADDR_DEB_GND)
			sh_dg = d[13:0];
		repeat (8) @(posedge clk_i);
	endtask

	task automatic give_verdict();
		$display("comparisons %0d n_fail %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// =========================================================
	// sequence
	initial begin
		repeat (6) @(posedge clk_i);
		rst_n_i <= 1'b1;
		@(posedge clk_i);
		// a read carrying ones must not write; spare bits must drop
		for (int k = 0; k < 3; k++) begin
			io(lp_cfg_pkg::ADDR_SLOW_GND + 7'(k), 1'b0, 24'hffffff);
			io(lp_cfg_pkg::ADDR_SLOW_GND + 7'(k), 1'b1, 24'hffffff);
		end
		io(lp_cfg_pkg::ADDR_SLEEP, 1'b0, 24'h000000);
		fault <= 1'b0;
		intf <= 1'b1;
		io(lp_cfg_pkg::ADDR_SW_STATUS, 1'b0, 24'h000000);
		io(lp_cfg_pkg::ADDR_FAULT_STATUS, 1'b0, 24'h000000);
		check(n_ic, 1);
		check(n_fc, 1);
		io(lp_cfg_pkg::ADDR_SLEEP, 1'b1, 24'h000001);
		io(lp_cfg_pkg::ADDR_SLOW_GND, 1'b1, 24'h000001);
		io(lp_cfg_pkg::ADDR_DEB_GND, 1'b1, 24'h000002);
		io(lp_cfg_pkg::ADDR_DEB_PROG, 1'b1, 24'h000001);
		check(lp, 1'b0);
		io(lp_cfg_pkg::ADDR_SLEEP, 1'b1, lp_cfg_pkg::SLEEP_DATA);
		check({timer_run, lp}, 2'b11);
		repeat (16 * PER) @(posedge clk_i);
		check(dt_norm, PER);
		check(dt_lvl, DEB);
		check(n_lvlp, n_lvl);
		check(n_slow, (n_norm + 3) / 4);
		check(n_bad, 0);
		check(len_g, POLL);
		check(len_p, POLL + DEB);
		wake <= 1'b1;
		@(posedge clk_i);
		wake <= 1'b0;
		pend = 1'b1;
		repeat (4) @(posedge clk_i);
		check({timer_run, lp}, 2'b00);
		check({src_g, src_p}, 22'h000000);
		io(lp_cfg_pkg::ADDR_SLOW_GND, 1'b0, 24'h000000);
		io(lp_cfg_pkg::ADDR_DEB_PROG, 1'b0, 24'h000000);
		io(lp_cfg_pkg::ADDR_DEB_GND, 1'b0, 24'h000000);
		io(lp_cfg_pkg::ADDR_SLEEP, 1'b0, 24'h000000);
		give_verdict();
	end
endmodule
